// file: logic/spr_pkg.sv
// constants, types and text for the serial printer interface
// Summary of operation
// - full duplex serial link, 19200 bits per second
// - ready/busy or x-on/x-off flow control selectable
// - received bytes buffered in 8192 byte memory
// - after printer reset, load timer and serial mode
// - drive dtr, busy, td, rts; sample dsr, cts, cd, rd
// - ready/busy mode reports state on busy line
// - bytes go to printer with write strobe
// - diagnostic plus loop plug runs test; select toggles
// - each pass prints revision digits then title
// - memory check prints ok or bad
// - lines low: dsr, cts, cd all low means pass
// - lines high: dsr, cts, cd all high means pass
// - send 20h to 7fh, store looped characters
// - print stored characters, then repeat pass
package spr_pkg;
    // clock and line rate
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned BIT_RATE = 19_200;
    localparam int unsigned BIT_CYCLES = CLK_HZ / BIT_RATE;
    localparam logic [10:0] BIT_LAST = 11'(BIT_CYCLES - 1);
    localparam logic [10:0] HALF_LAST = 11'(BIT_CYCLES / 2 - 1);
    // start, eight data bits, stop: bit index of the stop bit
    localparam logic [3:0] STOP_BIT = 4'H9;
    // message buffer size and flow marks
    localparam int unsigned ADDR_W = 13;
    localparam logic [13:0] BUF_FULL = 14'H2000;
    localparam logic [13:0] BUSY_MARK = 14'H1F00;
    localparam logic [13:0] READY_MARK = 14'H1C00;
    localparam logic [12:0] ADDR_LAST = 13'H1FFF;
    // flow control characters
    localparam logic [7:0] CHR_XON = 8'H11;
    localparam logic [7:0] CHR_XOFF = 8'H13;
    // echo range and digit base
    localparam logic [7:0] ECHO_FIRST = 8'H20;
    localparam logic [7:0] ECHO_LAST = 8'H7F;
    localparam logic [7:0] ASCII_ZERO = 8'H30;
    // wait counts
    localparam logic [19:0] INIT_LAST = 20'H00004;
    localparam logic [19:0] SETTLE_LAST = 20'(BIT_CYCLES - 1);
    localparam logic [19:0] ECHO_WAIT = 20'(BIT_CYCLES * 40);
    // printed messages
    typedef enum logic [2:0] {
        MSG_TITLE, MSG_OK, MSG_BAD, MSG_IF_OK, MSG_IF_BAD, MSG_EOL
    } spr_msg_t;
    // test and run phases
    typedef enum logic [3:0] {
        PH_INIT, PH_RUN, PH_IDLE, PH_REV, PH_MSG, PH_MEMW, PH_MEMR,
        PH_IFLO, PH_IFHI, PH_ECHO, PH_DRAIN, PH_PRINT
    } spr_phase_t;
    // message text, right aligned
    function automatic logic [127:0] msg_text(spr_msg_t m);
        unique case (m)
            MSG_TITLE: return 128'("LOOP TEST\r\n");
            MSG_OK: return 128'("OK\r\n");
            MSG_BAD: return 128'("BAD\r\n");
            MSG_IF_OK: return 128'("IF OK\r\n");
            MSG_IF_BAD: return 128'("IF BAD\r\n");
            MSG_EOL: return 128'("\r\n");
            default: return 128'H0; // unused code, prints a null
        endcase
    endfunction
    // message length in bytes
    function automatic logic [3:0] msg_len(spr_msg_t m);
        unique case (m)
            MSG_TITLE: return 4'HB;
            MSG_OK: return 4'H4;
            MSG_BAD: return 4'H5;
            MSG_IF_OK: return 4'H7;
            MSG_IF_BAD: return 4'H8;
            MSG_EOL: return 4'H2;
            default: return 4'H1; // unused code, one byte
        endcase
    endfunction
    // byte i of message m, first byte first
    function automatic logic [7:0] msg_byte(spr_msg_t m, logic [3:0] i);
        logic [127:0] t;
        int k;
        t = msg_text(m);
        k = int'(msg_len(m)) - 1 - int'(i);
        return t[k * 8 +: 8];
    endfunction
endpackage

// file: logic/spr_stream_if.sv
// byte stream with valid and ready between the controller and buffer
`timescale 1ns/1ps
interface spr_stream_if;
    logic valid; // byte offered
    logic ready; // byte taken when both high
    logic [7:0] data; // offered byte
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface // spr_stream_if

// file: logic/spr_pair_buffer.sv
// two-entry buffer in front of the printer parallel port
`timescale 1ns/1ps
module spr_pair_buffer (
    input wire logic clk,
    input wire logic rst,
    spr_stream_if.snk feed,
    input wire logic printer_ready,
    output logic [7:0] parallel_data_bus,
    output logic write_strobe
);
    // whole state of the buffer
    typedef struct packed {
        logic [7:0] head; // oldest byte, on the bus
        logic [7:0] tail; // second byte
        logic [1:0] used; // entries held
    } spr_pair_t;
    spr_pair_t s;
    spr_pair_t next_s;
    logic pop;
    logic push;

    // handshakes on both sides
    assign feed.ready = (s.used != 2'H2);
    assign write_strobe = (s.used != 2'H0) && printer_ready;
    assign parallel_data_bus = s.head;
    assign pop = write_strobe;
    assign push = feed.valid && feed.ready;

    // shift on pop, append on push
    always_comb begin
        next_s = s;
        if (pop) begin
            next_s.head = s.tail;
        end
        if (push) begin
            if (s.used == 2'H0 || (s.used == 2'H1 && pop)) begin
                next_s.head = feed.data;
            end else begin
                next_s.tail = feed.data;
            end
        end
        next_s.used = 2'(s.used + {1'b0, push} - {1'b0, pop});
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // spr_pair_buffer

// file: logic/spr_serial_printer.sv
// serial printer interface controller with loop self-test
`timescale 1ns/1ps
module spr_serial_printer #(
    parameter logic [7:0] PROGRAM_REVISION = 8'H10 // bcd, arbitrary
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic rx_pin,
    input wire logic dsr,
    input wire logic cts,
    input wire logic cd,
    input wire logic select_switch,
    input wire logic diag_mode,
    input wire logic loop_plug,
    input wire logic xon_mode,
    input wire logic printer_ready,
    output logic tx_pin,
    output logic dtr,
    output logic rts,
    output logic busy_line_out,
    output logic [7:0] parallel_data_bus,
    output logic write_strobe
);
    // whole controller state
    typedef struct packed {
        spr_pkg::spr_phase_t phase; // current phase
        spr_pkg::spr_phase_t after; // phase after a message
        spr_pkg::spr_msg_t msg; // message being printed
        logic [3:0] idx; // byte index in message
        logic proto; // latched flow mode, high for x-on/x-off
        logic test_on; // loop test selected at start
        logic running; // loop test running
        logic sel_prev; // select level last cycle
        logic [6:0] sync1; // first synchroniser stage
        logic [6:0] sync2; // second synchroniser stage
        logic rx_prev; // line level last cycle
        logic [12:0] wr_ptr; // buffer write address
        logic [12:0] rd_ptr; // buffer read address
        logic [13:0] fill; // bytes held
        logic [12:0] addr; // memory test address
        logic mem_ok; // memory check result
        logic host_go; // host may send
        logic flow_req; // flow character waiting
        logic [7:0] flow_chr; // flow character
        logic tx_busy; // frame being sent
        logic [9:0] tx_shift; // outgoing frame, lsb on line
        logic [3:0] tx_bit; // bit being sent
        logic [10:0] tx_tick; // cycles within bit
        logic rx_busy; // frame being received
        logic [7:0] rx_shift; // incoming data
        logic [3:0] rx_bit; // bit being received
        logic [10:0] rx_tick; // cycles within bit
        logic [7:0] chr; // next echo character
        logic [19:0] timer; // settle and wait counter
        logic line_lvl; // test level on output lines
        logic busy_out; // busy line register
    } spr_ctl_t;
    spr_ctl_t s;
    spr_ctl_t next_s;
    // message buffer memory
    logic [7:0] mem [0:spr_pkg::BUF_FULL - 1];
    logic mem_we;
    logic [12:0] mem_wa;
    logic [7:0] mem_wd;
    logic [7:0] mem_rd;
    // stream into the printer buffer
    spr_stream_if feed();
    logic push_valid;
    logic [7:0] push_data;
    logic pushed;
    // synchronised inputs
    logic rxd;
    logic in_dsr;
    logic in_cts;
    logic in_cd;
    logic in_sel;
    logic in_diag;
    logic in_plug;
    // one-cycle events
    logic rx_done;
    logic tx_load;
    logic [7:0] tx_char;
    logic store;
    logic take;
    logic sel_press;

    // test pattern written to each address
    function automatic logic [7:0] pattern(logic [12:0] a);
        return a[7:0] ^ {3'H0, a[12:8]};
    endfunction

    assign {in_plug, in_diag, in_sel, in_cd, in_cts, in_dsr, rxd} = s.sync2;
    assign mem_rd = s.test_on && (s.phase == spr_pkg::PH_MEMR) ?
        mem[s.addr] : mem[s.rd_ptr];
    assign feed.valid = push_valid;
    assign feed.data = push_data;
    assign pushed = push_valid && feed.ready;
    // lines toward the host, all from flops
    assign tx_pin = s.tx_shift[0];
    assign dtr = s.line_lvl;
    assign rts = s.line_lvl;
    assign busy_line_out = s.busy_out;

    // printer side buffer, absorbs printer stalls
    spr_pair_buffer u_buf (
        .clk(clk),
        .rst(rst),
        .feed(feed.snk),
        .printer_ready(printer_ready),
        .parallel_data_bus(parallel_data_bus),
        .write_strobe(write_strobe)
    );

    // next state of the whole controller
    always_comb begin
        next_s = s;
        rx_done = 1'b0;
        tx_load = 1'b0;
        tx_char = spr_pkg::CHR_XON;
        store = 1'b0;
        take = 1'b0;
        push_valid = 1'b0;
        push_data = mem_rd;
        mem_we = 1'b0;
        mem_wa = s.wr_ptr;
        mem_wd = s.rx_shift;
        next_s.timer = '0;
        // pins pass two flops before use
        next_s.sync1 = {loop_plug, diag_mode, select_switch, cd, cts, dsr,
            rx_pin};
        next_s.sync2 = s.sync1;
        next_s.sel_prev = in_sel;
        sel_press = in_sel && !s.sel_prev;
        // receiver: centre of start bit, then one bit time apart
        next_s.rx_prev = rxd;
        if (!s.rx_busy) begin
            if (s.rx_prev && !rxd) begin
                next_s.rx_busy = 1'b1;
                next_s.rx_tick = '0;
                next_s.rx_bit = '0;
            end
        end else if (s.rx_tick == (s.rx_bit == 4'H0 ?
                spr_pkg::HALF_LAST : spr_pkg::BIT_LAST)) begin
            next_s.rx_tick = '0;
            if (s.rx_bit == 4'H0) begin
                // a glitch that is high again is no start bit
                next_s.rx_busy = !rxd;
                next_s.rx_bit = 4'H1;
            end else if (s.rx_bit == spr_pkg::STOP_BIT) begin
                next_s.rx_busy = 1'b0;
                rx_done = rxd; // framing error drops the byte
            end else begin
                next_s.rx_shift = {rxd, s.rx_shift[7:1]};
                next_s.rx_bit = 4'(s.rx_bit + 4'H1);
            end
        end else begin
            next_s.rx_tick = 11'(s.rx_tick + 11'H1);
        end
        // phase machine
        unique case (s.phase)
            spr_pkg::PH_INIT: begin
                // wait for pins to settle, then set serial mode
                next_s.timer = 20'(s.timer + 20'H1);
                if (s.timer == spr_pkg::INIT_LAST) begin
                    next_s.proto = in_diag ? 1'b0 : xon_mode;
                    next_s.test_on = in_diag && in_plug;
                    next_s.running = in_diag && in_plug;
                    next_s.idx = '0;
                    next_s.phase = (in_diag && in_plug) ?
                        spr_pkg::PH_REV : spr_pkg::PH_RUN;
                end
            end
            spr_pkg::PH_RUN: begin
                // received bytes into memory, memory to printer
                store = rx_done;
                push_valid = (s.fill != 14'H0);
                take = pushed;
                tx_load = s.flow_req && !s.tx_busy;
                tx_char = s.flow_chr;
            end
            spr_pkg::PH_IDLE: begin
                next_s.idx = '0;
            end
            spr_pkg::PH_REV: begin
                // two revision digits, then the title
                push_valid = 1'b1;
                push_data = spr_pkg::ASCII_ZERO + {4'H0, s.idx[0] ?
                PROGRAM_REVISION[3:0] : PROGRAM_REVISION[7:4]};
                if (pushed) begin
                    next_s.idx = 4'(s.idx + 4'H1);
                    if (s.idx[0]) begin
                        next_s.idx = '0;
                        next_s.msg = spr_pkg::MSG_TITLE;
                        next_s.after = spr_pkg::PH_MEMW;
                        next_s.addr = '0;
                        next_s.phase = spr_pkg::PH_MSG;
                    end
                end
            end
            spr_pkg::PH_MSG: begin
                // print one message, then move on
                push_valid = 1'b1;
                push_data = spr_pkg::msg_byte(s.msg, s.idx);
                if (pushed) begin
                    next_s.idx = 4'(s.idx + 4'H1);
                    if (s.idx == 4'(spr_pkg::msg_len(s.msg) - 4'H1)) begin
                        next_s.idx = '0;
                        next_s.phase = s.after;
                    end
                end
            end
            spr_pkg::PH_MEMW: begin
                // fill memory with an address pattern
                mem_we = 1'b1;
                mem_wa = s.addr;
                mem_wd = pattern(s.addr);
                next_s.addr = 13'(s.addr + 13'H1);
                if (s.addr == spr_pkg::ADDR_LAST) begin
                    next_s.mem_ok = 1'b1;
                    next_s.phase = spr_pkg::PH_MEMR;
                end
            end
            spr_pkg::PH_MEMR: begin
                // read back and compare
                next_s.addr = 13'(s.addr + 13'H1);
                next_s.mem_ok = s.mem_ok && (mem_rd == pattern(s.addr));
                if (s.addr == spr_pkg::ADDR_LAST) begin
                    next_s.msg = next_s.mem_ok ?
                        spr_pkg::MSG_OK : spr_pkg::MSG_BAD;
                    next_s.after = spr_pkg::PH_IFLO;
                    next_s.phase = spr_pkg::PH_MSG;
                end
            end
            spr_pkg::PH_IFLO: begin
                // lines low; plug must bring dsr, cts and cd low
                next_s.line_lvl = 1'b0;
                next_s.timer = 20'(s.timer + 20'H1);
                if (s.timer == spr_pkg::SETTLE_LAST) begin
                    next_s.msg = (!in_dsr && !in_cts && !in_cd) ?
                        spr_pkg::MSG_IF_OK : spr_pkg::MSG_IF_BAD;
                    next_s.after = spr_pkg::PH_IFHI;
                    next_s.phase = spr_pkg::PH_MSG;
                end
            end
            spr_pkg::PH_IFHI: begin
                // lines high; plug must bring dsr, cts and cd high
                next_s.line_lvl = 1'b1;
                next_s.timer = 20'(s.timer + 20'H1);
                if (s.timer == spr_pkg::SETTLE_LAST) begin
                    next_s.msg = (in_dsr && in_cts && in_cd) ?
                        spr_pkg::MSG_IF_OK : spr_pkg::MSG_IF_BAD;
                    next_s.after = spr_pkg::PH_ECHO;
                    next_s.phase = spr_pkg::PH_MSG;
                    next_s.chr = spr_pkg::ECHO_FIRST;
                    next_s.wr_ptr = '0;
                    next_s.rd_ptr = '0;
                    next_s.fill = '0;
                end
            end
            spr_pkg::PH_ECHO: begin
                // send the printable range, store what comes back
                store = rx_done;
                tx_load = !s.tx_busy;
                tx_char = s.chr;
                if (tx_load) begin
                    next_s.chr = 8'(s.chr + 8'H1);
                    if (s.chr == spr_pkg::ECHO_LAST) begin
                        next_s.phase = spr_pkg::PH_DRAIN;
                    end
                end
            end
            spr_pkg::PH_DRAIN: begin
                // let the last characters come back
                store = rx_done;
                next_s.timer = 20'(s.timer + 20'H1);
                if (s.timer == spr_pkg::ECHO_WAIT) begin
                    next_s.phase = spr_pkg::PH_PRINT;
                end
            end
            spr_pkg::PH_PRINT: begin
                // print stored characters, then start over
                push_valid = (s.fill != 14'H0);
                take = pushed;
                if (s.fill == 14'H0) begin
                    next_s.msg = spr_pkg::MSG_EOL;
                    next_s.after = spr_pkg::PH_REV;
                    next_s.phase = spr_pkg::PH_MSG;
                end
            end
        endcase
        // receive store and printer take on the ring
        if (store && s.fill != spr_pkg::BUF_FULL) begin
            mem_we = 1'b1;
            mem_wa = s.wr_ptr;
            mem_wd = s.rx_shift;
            next_s.wr_ptr = 13'(s.wr_ptr + 13'H1);
        end
        if (take) begin
            next_s.rd_ptr = 13'(s.rd_ptr + 13'H1);
        end
        if (store || take) begin
            next_s.fill = 14'(s.fill + {13'H0, mem_we && store} -
                {13'H0, take});
        end
        // flow control with hysteresis on the fill level
        if (s.phase == spr_pkg::PH_RUN) begin
            if (tx_load) begin
                next_s.flow_req = 1'b0;
            end
            if (s.host_go && next_s.fill >= spr_pkg::BUSY_MARK) begin
                next_s.host_go = 1'b0;
                next_s.flow_req = s.proto;
                next_s.flow_chr = spr_pkg::CHR_XOFF;
            end else if (!s.host_go && next_s.fill <= spr_pkg::READY_MARK)
                begin
                next_s.host_go = 1'b1;
                next_s.flow_req = s.proto;
                next_s.flow_chr = spr_pkg::CHR_XON;
            end
        end
        // transmitter: start, eight data bits, stop
        if (s.tx_busy) begin
            if (s.tx_tick == spr_pkg::BIT_LAST) begin
                next_s.tx_tick = '0;
                next_s.tx_shift = {1'b1, s.tx_shift[9:1]};
                next_s.tx_busy = (s.tx_bit != spr_pkg::STOP_BIT);
                next_s.tx_bit = 4'(s.tx_bit + 4'H1);
            end else begin
                next_s.tx_tick = 11'(s.tx_tick + 11'H1);
            end
        end else if (tx_load) begin
            next_s.tx_busy = 1'b1;
            next_s.tx_shift = {1'b1, tx_char, 1'b0};
            next_s.tx_bit = '0;
            next_s.tx_tick = '0;
        end
        // select toggles the loop test
        if (s.test_on && sel_press) begin
            next_s.running = !s.running;
            next_s.idx = '0;
            next_s.phase = s.running ? spr_pkg::PH_IDLE : spr_pkg::PH_REV;
        end
        // busy line follows the test level or the flow state
        next_s.busy_out = s.test_on ? next_s.line_lvl :
            (s.proto || next_s.host_go);
    end

    // message buffer write port
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // state register, held while the printer keeps reset high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.phase <= spr_pkg::PH_INIT;
            s.host_go <= 1'b1;
            s.line_lvl <= 1'b1;
            s.busy_out <= 1'b1;
            s.tx_shift <= '1;
            s.sync1 <= '1;
            s.sync2 <= '1;
            s.rx_prev <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule // spr_serial_printer

// file: bench/spr_serial_printer_props.sv
// port assertions for the serial printer interface
`timescale 1ns/1ps
module spr_serial_printer_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic diag_mode,
    input wire logic loop_plug,
    input wire logic xon_mode,
    input wire logic printer_ready,
    input wire logic tx_pin,
    input wire logic dtr,
    input wire logic rts,
    input wire logic busy_line_out,
    input wire logic write_strobe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [15:0] low_run; // cycles the transmit line has been low
    // length of the current low stretch on the transmit line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_run <= 16'H0000;
        end else begin
            low_run <= tx_pin ? 16'H0000 : low_run + 16'H0001;
        end
    end
    property p_init_quiet;
        $fell(rst) |-> (tx_pin && !write_strobe) [*5];
    endproperty
    a_init_quiet: assert property (p_init_quiet)
        else $error("output active during init");
    property p_strobe_ready; write_strobe |-> printer_ready; endproperty
    a_strobe_ready: assert property (p_strobe_ready)
        else $error("strobe without printer ready");
    property p_tx_bits;
        $rose(tx_pin) |-> low_run % spr_pkg::BIT_CYCLES == 0;
    endproperty
    a_tx_bits: assert property (p_tx_bits)
        else $error("low stretch not whole bit times");
    property p_dtr_rts; dtr == rts; endproperty
    a_dtr_rts: assert property (p_dtr_rts)
        else $error("dtr and rts differ");
    property p_normal_high; !diag_mode |-> dtr && rts; endproperty
    a_normal_high: assert property (p_normal_high)
        else $error("handshake low in normal mode");
    property p_xon_busy;
        xon_mode && !diag_mode |-> busy_line_out;
    endproperty
    a_xon_busy: assert property (p_xon_busy)
        else $error("busy line low in x-on mode");
    property p_loop_pair;
        diag_mode && loop_plug |-> busy_line_out == dtr;
    endproperty
    a_loop_pair: assert property (p_loop_pair)
        else $error("busy line not with dtr in test");
    property p_lines_low; $fell(dtr) |-> !dtr [*8]; endproperty
    a_lines_low: assert property (p_lines_low)
        else $error("lines low too briefly");
    c_strobe: cover property (write_strobe);
    c_lines_low: cover property ($fell(dtr));
    c_tx_frame: cover property ($rose(tx_pin));
endmodule // spr_serial_printer_props
bind spr_serial_printer spr_serial_printer_props i_props (
    .clk(clk), .rst(rst), .diag_mode(diag_mode), .loop_plug(loop_plug),
    .xon_mode(xon_mode), .printer_ready(printer_ready), .tx_pin(tx_pin),
    .dtr(dtr), .rts(rts), .busy_line_out(busy_line_out),
    .write_strobe(write_strobe)
);

// file: bench/spr_host_model.sv
// host computer and loopback plug on the serial side
`timescale 1ns/1ps
module spr_host_model (
    input wire logic clk,
    input wire logic loop_en,
    input wire logic tx_pin,
    input wire logic dtr,
    input wire logic rts,
    input wire logic busy_line_out,
    output logic rx_pin,
    output logic dsr,
    output logic cts,
    output logic cd
);
    logic host_line = 1'b1; // host transmit line, idles high
    // plug loops data and handshake lines back to the board
    assign rx_pin = loop_en ? tx_pin : host_line;
    assign dsr = loop_en ? dtr : 1'b1;
    assign cts = loop_en ? rts : 1'b1;
    assign cd = loop_en ? busy_line_out : 1'b1;
    // one 8n1 frame, lsb first, held off while the board is busy
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        while (busy_line_out !== 1'b1) @(negedge clk);
        for (int i = 0; i < 10; i++) begin
            host_line = f[i];
            repeat (spr_pkg::BIT_CYCLES) @(negedge clk);
        end
    endtask
endmodule // spr_host_model

// file: bench/spr_serial_printer_tb.sv
// self-checking bench for the serial printer interface
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module spr_serial_printer_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic diag_mode = 1'b0;
    logic xon_mode = 1'b1;
    logic printer_ready = 1'b0;
    logic select_switch = 1'b0; // front key, released at rest
    logic rx_pin, dsr, cts, cd, tx_pin, dtr, rts, busy_line_out, write_strobe;
    logic [7:0] parallel_data_bus;
    logic [7:0] want[$]; // expected printer bytes, oldest first
    logic [7:0] exp_b; // byte taken off the queue
    logic [31:0] seed = 32'H5172C863; // random source state
    int miscompares = 0;
    int checked = 0;
    // 50 ns clock
    always #25 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    spr_serial_printer i_dut (.clk(clk), .rst(rst), .rx_pin(rx_pin),
        .dsr(dsr), .cts(cts), .cd(cd), .select_switch(select_switch),
        .diag_mode(diag_mode), .loop_plug(diag_mode), .xon_mode(xon_mode),
        .printer_ready(printer_ready), .tx_pin(tx_pin), .dtr(dtr),
        .rts(rts), .busy_line_out(busy_line_out),
        .parallel_data_bus(parallel_data_bus), .write_strobe(write_strobe));
    spr_host_model i_host (.clk(clk), .loop_en(diag_mode), .tx_pin(tx_pin),
        .dtr(dtr), .rts(rts), .busy_line_out(busy_line_out),
        .rx_pin(rx_pin), .dsr(dsr), .cts(cts), .cd(cd));
    // printer stalls at random
    always @(negedge clk) begin
        seed <= lfsr(seed);
        printer_ready <= seed[3] | seed[9];
    end
    // every strobed byte is matched with the oldest expected byte
    always @(posedge clk) begin
        if (write_strobe === 1'b1) begin
            `CHK(want.size() != 0, 1'b1)
            if (want.size() != 0) begin
                exp_b = want.pop_front();
                `CHK(parallel_data_bus, exp_b)
            end
        end
    end
    task automatic print_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // reset into normal or test mode, idle outputs checked
    task automatic reset_dut(input logic diag);
        rst = 1'b1;
        diag_mode = diag;
        xon_mode = !diag;
        repeat (12) @(negedge clk);
        `CHK({tx_pin, dtr, rts, busy_line_out, write_strobe}, 5'H1E)
        rst = 1'b0;
        repeat (6) @(negedge clk);
    endtask
    // wait, bounded, until all expected bytes were printed
    task automatic drain(input int limit);
        for (int k = 0; k < limit && want.size() != 0; k++) @(negedge clk);
        `CHK(want.size(), 0)
    endtask
    // one press of the front key, long enough for the synchroniser
    task automatic press_select();
        select_switch = 1'b1;
        repeat (4) @(negedge clk);
        select_switch = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // sample one frame on the transmit line at the bit centres
    task automatic grab_frame(output logic [7:0] b);
        for (int k = 0; k < 2000 && tx_pin !== 1'b0; k++) @(negedge clk);
        repeat (spr_pkg::BIT_CYCLES / 2) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (spr_pkg::BIT_CYCLES) @(negedge clk);
            b[i] = tx_pin;
        end
    endtask
    // main sequence
    initial begin
        string s;
        logic [7:0] got; // first echoed frame seen on the line
        reset_dut(1'b0);
        // random frames back to back, printer stalling
        for (int i = 0; i < 3; i++) begin
            want.push_back(seed[7:0]);
            i_host.send_byte(seed[7:0]);
        end
        drain(4000);
        $display("test receive done");
        // loop test: revision digits, title, memory and line checks
        reset_dut(1'b1);
        s = "10LOOP TEST\r\nOK\r\nIF OK\r\nIF OK\r\n";
        for (int i = 0; i < s.len(); i++) want.push_back(s[i]);
        drain(30000);
        grab_frame(got);
        `CHK(got, spr_pkg::ECHO_FIRST)
        $display("test loop done");
        // a press stops the pass: the line goes quiet after this frame
        press_select();
        repeat (2000) @(negedge clk);
        `CHK(tx_pin, 1'b1)
        // a second press starts again from the revision digits
        for (int i = 0; i < s.len(); i++) want.push_back(s[i]);
        press_select();
        drain(30000);
        $display("test select done");
        print_verdict();
    end
    // hang guard
    initial begin
        #5000000;
        miscompares++;
        print_verdict();
    end
endmodule // spr_serial_printer_tb
